// ==== core/dtpm_pkg.sv ====
package dtpm_pkg;
    // Pin slots of the muxed group
    localparam int unsigned NPIN   = 6;
    localparam int unsigned PIN_C0 = 0;
    localparam int unsigned PIN_C1 = 1;
    localparam int unsigned PIN_C3 = 2;
    localparam int unsigned PIN_C4 = 3;
    localparam int unsigned PIN_B0 = 4;
    localparam int unsigned PIN_B7 = 5;

    // Register bus widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_DEBUG_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PORT_B_LOW   = 8'h04;
    localparam logic [7:0] OFS_PORT_B_HIGH  = 8'h08;
    localparam logic [7:0] OFS_PORT_C_LOW   = 8'h0C;
    localparam logic [7:0] OFS_PORT_C_HIGH  = 8'h10;
    localparam logic [7:0] OFS_IRQ_C_SEL    = 8'h14;
    localparam logic [7:0] OFS_IRQ_D_SEL    = 8'h18;
    localparam logic [7:0] OFS_GPIO_OUT     = 8'h1C;
    localparam logic [7:0] OFS_GPIO_IN      = 8'h20;
    localparam logic [7:0] OFS_STATUS       = 8'h24;

    // Field positions
    localparam int unsigned DBGCFG_GPIO_BIT = 5;
    localparam int unsigned B0_LSB = 0;
    localparam int unsigned B7_LSB = 12;
    localparam int unsigned C0_LSB = 0;
    localparam int unsigned C1_LSB = 4;
    localparam int unsigned C3_LSB = 12;
    localparam int unsigned C4_LSB = 0;

    // Port configuration field codes
    localparam logic [3:0] CFG_ANALOG  = 4'h0;
    localparam logic [3:0] CFG_OUT     = 4'h1;
    localparam logic [3:0] CFG_INPUT   = 4'h4;
    localparam logic [3:0] CFG_OUT_OD  = 4'h5;
    localparam logic [3:0] CFG_IN_PULL = 4'h8;
    localparam logic [3:0] CFG_ALT_OUT = 4'h9;
    localparam logic [3:0] CFG_ALT_OD  = 4'hD;

    // Values after reset
    localparam logic [15:0] RST_PORT_CFG   = 16'h4444;
    localparam logic [7:0]  RST_DEBUG_CFG  = 8'h00;
    localparam logic [2:0]  RST_IRQ_C_SEL  = 3'h5;
    localparam logic [2:0]  RST_IRQ_D_SEL  = 3'h0;
    localparam logic [5:0]  RST_GPIO_OUT   = 6'h00;

    // Core trace width codes
    localparam logic [1:0] TRACE_W1 = 2'h0;
    localparam logic [1:0] TRACE_W2 = 2'h1;
    localparam logic [1:0] TRACE_W4 = 2'h2;

    // Debug port mode
    typedef enum logic {
        DBG_JTAG,
        DBG_SWD
    } dtpm_dbg_mode_t;

    // Drive of one pad
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic analog;
    } dtpm_pin_drive_t;

    // Trace settings from the core
    typedef struct packed {
        logic       enable;
        logic       async;
        logic [1:0] width;
        logic       clock;
        logic       data0;
        logic       data1;
        logic       async_out;
    } dtpm_trace_t;
endpackage

// ==== core/dtpm_pin_mux.sv ====
// Our own choices: the register offsets and strobed register access.
module dtpm_pin_mux (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // Register port
    input  wire logic [dtpm_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [dtpm_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [dtpm_pkg::DATA_W-1:0] reg_rdata,
    // Pads
    input  wire logic [dtpm_pkg::NPIN-1:0]   pad_in,
    output logic      [dtpm_pkg::NPIN-1:0]   pad_out,
    output logic      [dtpm_pkg::NPIN-1:0]   pad_oe,
    output logic      [dtpm_pkg::NPIN-1:0]   pad_pull_up,
    output logic      [dtpm_pkg::NPIN-1:0]   pad_analog,
    // Debug engine
    input  wire logic                        swd_select,
    input  wire logic                        jtag_select,
    input  wire logic                        swdio_out,
    input  wire logic                        swdio_oe,
    output logic                             test_data_in,
    output logic                             test_mode_select,
    output logic                             test_reset_in_n,
    output logic                             swdio_in,
    // Core trace
    input  wire dtpm_pkg::dtpm_trace_t       trace,
    // Timers
    input  wire logic                        timer_one_output_enable,
    input  wire logic                        timer_one_ch2_out,
    output logic                             timer_one_channel2,
    output logic                             timer_one_ext_clock,
    output logic                             timer_two_clock_mask,
    // External interrupts
    output logic                             ext_interrupt_a,
    output logic                             ext_interrupt_c,
    output logic                             ext_interrupt_d
);
    import dtpm_pkg::*;

    // Pad drive for one configuration field
    function automatic dtpm_pin_drive_t port_drive(
        input logic [3:0] cfg,
        input logic       data,
        input logic       alt_en,
        input logic       alt_val
    );
        dtpm_pin_drive_t d;
        logic            v;
        d = '0;
        v = alt_en ? alt_val : data;
        case (cfg)
            CFG_ANALOG: begin // Analog path, digital off
                d.analog = 1'b1;
            end
            CFG_OUT: begin // Push-pull GPIO
                d.oe  = 1'b1;
                d.out = data;
            end
            CFG_OUT_OD: begin // Open-drain GPIO
                d.oe = ~data;
            end
            CFG_IN_PULL: begin // Input with pull-up
                d.pull_up = 1'b1;
            end
            CFG_ALT_OUT: begin // Alternate or GPIO data
                d.oe  = 1'b1;
                d.out = v;
            end
            CFG_ALT_OD: begin // Alternate open-drain
                d.oe = ~v;
            end
            default: begin // Plain input
                d = '0;
            end
        endcase
        return d;
    endfunction

    // Software registers
    logic [7:0]       debug_config_q;      // Debug pin release
    logic [15:0]      port_b_low_config_q; // Port B low fields
    logic [15:0]      port_b_high_config_q;// Port B high fields
    logic [15:0]      port_c_low_config_q; // Port C low fields
    logic [15:0]      port_c_high_config_q;// Port C high fields
    logic [2:0]       irq_c_sel_q;         // Interrupt C source
    logic [2:0]       irq_d_sel_q;         // Interrupt D source
    logic [NPIN-1:0]  gpio_out_q;          // GPIO output data
    dtpm_dbg_mode_t   mode_q;              // Debug port mode

    // Input synchronisers and filtered levels
    logic [NPIN-1:0]  sync1_q;
    logic [NPIN-1:0]  sync2_q;
    logic [NPIN-1:0]  sync3_q;
    logic [NPIN-1:0]  pin_q;

    // Per-pin configuration fields
    wire logic [3:0] cfg_c0 = port_c_low_config_q[C0_LSB +: 4];
    wire logic [3:0] cfg_c1 = port_c_low_config_q[C1_LSB +: 4];
    wire logic [3:0] cfg_c3 = port_c_low_config_q[C3_LSB +: 4];
    wire logic [3:0] cfg_c4 = port_c_high_config_q[C4_LSB +: 4];
    wire logic [3:0] cfg_b0 = port_b_low_config_q[B0_LSB +: 4];
    wire logic [3:0] cfg_b7 = port_b_high_config_q[B7_LSB +: 4];

    // Mode decode
    wire logic jtag_on  = (mode_q == DBG_JTAG);
    wire logic swd_on   = (mode_q == DBG_SWD);
    wire logic dbg_gpio = debug_config_q[DBGCFG_GPIO_BIT];

    // Trace decode
    wire logic sync_on  = trace.enable & ~trace.async;
    wire logic wide_on  = (trace.width == TRACE_W2) | (trace.width == TRACE_W4);
    wire logic w_valid  = wide_on | (trace.width == TRACE_W1);
    wire logic bit1_on  = sync_on & wide_on & (cfg_c0 == CFG_ALT_OUT);
    wire logic c1_alt   = trace.enable & (trace.async | w_valid);
    wire logic c1_val   = trace.async ? trace.async_out : trace.data0;

    // GPIO ownership of debug pins
    wire logic c0_gpio  = dbg_gpio | (swd_on & ~bit1_on);
    wire logic c3_gpio  = dbg_gpio | swd_on;
    wire logic c4_gpio  = dbg_gpio;
    wire logic rst_path = jtag_on & ~bit1_on & ~dbg_gpio;

    // Pull-up only drive for debug inputs
    localparam dtpm_pin_drive_t PULL_ONLY = '{out: 1'b0, oe: 1'b0,
                                             pull_up: 1'b1, analog: 1'b0};

    // Serial data drive
    wire dtpm_pin_drive_t swd_drv = '{out: swdio_out, oe: swdio_oe,
                                      pull_up: 1'b1, analog: 1'b0};

    // Next drive of each pad
    dtpm_pin_drive_t drv [NPIN];

    // port_c0: trace bit1, GPIO, or test reset input
    assign drv[PIN_C0] = (c0_gpio | bit1_on)
                       ? port_drive(cfg_c0, gpio_out_q[PIN_C0], bit1_on,
                                    trace.data1)
                       : PULL_ONLY;
    // port_c1: ADC input 3 or trace output
    assign drv[PIN_C1] = port_drive(cfg_c1, gpio_out_q[PIN_C1], c1_alt,
                                    c1_val);
    // port_c3: GPIO or test data input
    assign drv[PIN_C3] = c3_gpio
                       ? port_drive(cfg_c3, gpio_out_q[PIN_C3], 1'b0, 1'b0)
                       : PULL_ONLY;
    // port_c4: GPIO, serial data, or mode select
    assign drv[PIN_C4] = c4_gpio
                       ? port_drive(cfg_c4, gpio_out_q[PIN_C4], 1'b0, 1'b0)
                       : (swd_on ? swd_drv : PULL_ONLY);
    // port_b0: reference output or trace clock
    assign drv[PIN_B0] = port_drive(cfg_b0, gpio_out_q[PIN_B0], trace.enable,
                                    trace.clock);
    // port_b7: ADC input 2 or timer channel 2
    assign drv[PIN_B7] = port_drive(cfg_b7, gpio_out_q[PIN_B7],
                                    timer_one_output_enable,
                                    timer_one_ch2_out);

    // Per-pin pad registers and input filter
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            // Pad drive flops
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pad_out[gi]     <= 1'b0;
                    pad_oe[gi]      <= 1'b0;
                    pad_pull_up[gi] <= 1'b0;
                    pad_analog[gi]  <= 1'b0;
                end else begin
                    pad_out[gi]     <= drv[gi].out;
                    pad_oe[gi]      <= drv[gi].oe;
                    pad_pull_up[gi] <= drv[gi].pull_up;
                    pad_analog[gi]  <= drv[gi].analog;
                end
            end
            // Three-stage sync, accept when stages agree
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                    sync3_q[gi] <= 1'b1;
                    pin_q[gi]   <= 1'b1;
                end else begin
                    sync1_q[gi] <= pad_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Debug mode; reset forces JTAG
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= DBG_JTAG;
        end else if (swd_select) begin
            mode_q <= DBG_SWD;
        end else if (jtag_select) begin
            mode_q <= DBG_JTAG;
        end
    end

    // Interrupt source decode
    wire logic irq_c_val = (irq_c_sel_q < 3'(NPIN)) ? pin_q[irq_c_sel_q] : 1'b0;
    wire logic irq_d_val = (irq_d_sel_q < 3'(NPIN)) ? pin_q[irq_d_sel_q] : 1'b0;

    // Function inputs to debug logic, timers, interrupts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            test_data_in         <= 1'b1;
            test_mode_select     <= 1'b1;
            test_reset_in_n      <= 1'b1;
            swdio_in             <= 1'b1;
            timer_one_channel2   <= 1'b0;
            timer_one_ext_clock  <= 1'b0;
            timer_two_clock_mask <= 1'b0;
            ext_interrupt_a      <= 1'b0;
            ext_interrupt_c      <= 1'b0;
            ext_interrupt_d      <= 1'b0;
        end else begin
            test_data_in         <= (jtag_on & ~c3_gpio) ? pin_q[PIN_C3] : 1'b1;
            test_mode_select     <= (jtag_on & ~c4_gpio) ? pin_q[PIN_C4] : 1'b1;
            test_reset_in_n      <= rst_path ? pin_q[PIN_C0] : 1'b1;
            swdio_in             <= (swd_on & ~c4_gpio) ? pin_q[PIN_C4] : 1'b1;
            timer_one_channel2   <= pin_q[PIN_B7];
            timer_one_ext_clock  <= pin_q[PIN_B0];
            timer_two_clock_mask <= pin_q[PIN_B0];
            ext_interrupt_a      <= pin_q[PIN_B0];
            ext_interrupt_c      <= irq_c_val;
            ext_interrupt_d      <= irq_d_val;
        end
    end

    // Write decode
    wire logic wr_dbg   = reg_wr & (reg_addr == OFS_DEBUG_CONFIG);
    wire logic wr_bl    = reg_wr & (reg_addr == OFS_PORT_B_LOW);
    wire logic wr_bh    = reg_wr & (reg_addr == OFS_PORT_B_HIGH);
    wire logic wr_cl    = reg_wr & (reg_addr == OFS_PORT_C_LOW);
    wire logic wr_ch    = reg_wr & (reg_addr == OFS_PORT_C_HIGH);
    wire logic wr_ext_interrupt_c  = reg_wr & (reg_addr == OFS_IRQ_C_SEL);
    wire logic wr_ext_interrupt_d  = reg_wr & (reg_addr == OFS_IRQ_D_SEL);
    wire logic wr_gpio  = reg_wr & (reg_addr == OFS_GPIO_OUT);

    // Configuration registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debug_config_q       <= RST_DEBUG_CFG;
            port_b_low_config_q  <= RST_PORT_CFG;
            port_b_high_config_q <= RST_PORT_CFG;
            port_c_low_config_q  <= RST_PORT_CFG;
            port_c_high_config_q <= RST_PORT_CFG;
            irq_c_sel_q          <= RST_IRQ_C_SEL;
            irq_d_sel_q          <= RST_IRQ_D_SEL;
            gpio_out_q           <= RST_GPIO_OUT;
        end else begin
            if (wr_dbg)  debug_config_q       <= reg_wdata[7:0];
            if (wr_bl)   port_b_low_config_q  <= reg_wdata[15:0];
            if (wr_bh)   port_b_high_config_q <= reg_wdata[15:0];
            if (wr_cl)   port_c_low_config_q  <= reg_wdata[15:0];
            if (wr_ch)   port_c_high_config_q <= reg_wdata[15:0];
            if (wr_ext_interrupt_c) irq_c_sel_q          <= reg_wdata[2:0];
            if (wr_ext_interrupt_d) irq_d_sel_q          <= reg_wdata[2:0];
            if (wr_gpio) gpio_out_q           <= reg_wdata[NPIN-1:0];
        end
    end

    // Read selection; unmapped reads zero
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        case (reg_addr)
            OFS_DEBUG_CONFIG: rd_mux = {24'h000000, debug_config_q};
            OFS_PORT_B_LOW:   rd_mux = {16'h0000, port_b_low_config_q};
            OFS_PORT_B_HIGH:  rd_mux = {16'h0000, port_b_high_config_q};
            OFS_PORT_C_LOW:   rd_mux = {16'h0000, port_c_low_config_q};
            OFS_PORT_C_HIGH:  rd_mux = {16'h0000, port_c_high_config_q};
            OFS_IRQ_C_SEL:    rd_mux = {29'h0, irq_c_sel_q};
            OFS_IRQ_D_SEL:    rd_mux = {29'h0, irq_d_sel_q};
            OFS_GPIO_OUT:     rd_mux = {26'h0, gpio_out_q};
            OFS_GPIO_IN:      rd_mux = {26'h0, pin_q};
            OFS_STATUS:       rd_mux = {30'h0, bit1_on, swd_on};
            default:          rd_mux = '0;
        endcase
    end

    // Read data valid the cycle after each reg_rd cycle, zero otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end
endmodule // dtpm_pin_mux

// ==== tb/dtpm_sva.sv ====
module dtpm_sva (
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        reset_n,
    // Register writes
    input wire logic [dtpm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dtpm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_wr,
    // Pads
    input wire logic [dtpm_pkg::NPIN-1:0]   pad_in,
    input wire logic [dtpm_pkg::NPIN-1:0]   pad_out,
    input wire logic [dtpm_pkg::NPIN-1:0]   pad_oe,
    input wire logic [dtpm_pkg::NPIN-1:0]   pad_pull_up,
    input wire logic [dtpm_pkg::NPIN-1:0]   pad_analog,
    // Debug, trace, timers and interrupt A
    input wire logic                        swd_select,
    input wire logic                        jtag_select,
    input wire logic                        swdio_out,
    input wire logic                        swdio_oe,
    input wire logic                        test_data_in,
    input wire logic                        test_mode_select,
    input wire logic                        test_reset_in_n,
    input wire dtpm_pkg::dtpm_trace_t       trace,
    input wire logic                        timer_one_output_enable,
    input wire logic                        timer_one_ch2_out,
    input wire logic                        timer_one_channel2,
    input wire logic                        timer_one_ext_clock,
    input wire logic                        timer_two_clock_mask,
    input wire logic                        ext_interrupt_a
);
    timeunit 1ns;
    timeprecision 1ns;
    import dtpm_pkg::*;
    logic       swd_q, gpio_q;      // Mirrored mode and release bit
    logic [3:0] b0_q, c1_q, b7_q;   // Mirrored pin fields
    wire w_dbg = reg_wr && reg_addr == OFS_DEBUG_CONFIG;
    wire w_blo = reg_wr && reg_addr == OFS_PORT_B_LOW;
    wire w_bhi = reg_wr && reg_addr == OFS_PORT_B_HIGH;
    wire w_clo = reg_wr && reg_addr == OFS_PORT_C_LOW;
    wire jtag_own = !swd_q && !gpio_q;  // Debug pins held by JTAG
    wire swd_own = swd_q && !gpio_q;    // Data pin held by serial debug
    wire clk_own = b0_q == CFG_ALT_OUT && trace.enable;
    wire ch2_own = b7_q == CFG_ALT_OUT && timer_one_output_enable;
    // Mirror of state; select pulse wins over JTAG pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {swd_q, gpio_q, b0_q, c1_q, b7_q} <= {2'b00, 12'h444};
        end else begin
            swd_q <= swd_select || (swd_q && !jtag_select);
            if (w_dbg) gpio_q <= reg_wdata[DBGCFG_GPIO_BIT];
            if (w_blo) b0_q <= reg_wdata[3:0];
            if (w_bhi) b7_q <= reg_wdata[15:12];
            if (w_clo) c1_q <= reg_wdata[7:4];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    jtag_pull_a: assert property ($past(reset_n) && $past(jtag_own) |->
        pad_pull_up[PIN_C3] && pad_pull_up[PIN_C4] && !pad_oe[PIN_C3] && !pad_oe[PIN_C4])
        else $error("jtag pins not pulled inputs");
    swd_data_a: assert property ($past(reset_n) && $past(swd_own) |-> pad_pull_up[PIN_C4]
        && pad_oe[PIN_C4] == $past(swdio_oe)
        && (!pad_oe[PIN_C4] || pad_out[PIN_C4] == $past(swdio_out)))
        else $error("serial data pin drive wrong");
    swd_unrouted_a: assert property (swd_q && $past(swd_q) && $past(swd_q, 2) |->
        test_reset_in_n && test_data_in && test_mode_select)
        else $error("jtag input routed in serial mode");
    b0_analog_a: assert property ($past(reset_n) |->
        pad_analog[PIN_B0] == ($past(b0_q) == CFG_ANALOG)) else $error("b0 analog wrong");
    c1_analog_a: assert property ($past(reset_n) |->
        pad_analog[PIN_C1] == ($past(c1_q) == CFG_ANALOG)) else $error("c1 analog wrong");
    b7_analog_a: assert property ($past(reset_n) |->
        pad_analog[PIN_B7] == ($past(b7_q) == CFG_ANALOG)) else $error("b7 analog wrong");
    trace_clk_a: assert property ($past(reset_n) && $past(clk_own) |->
        pad_oe[PIN_B0] && pad_out[PIN_B0] == $past(trace.clock))
        else $error("b0 trace clock wrong");
    ch2_out_a: assert property ($past(reset_n) && $past(ch2_own) |->
        pad_oe[PIN_B7] && pad_out[PIN_B7] == $past(timer_one_ch2_out))
        else $error("b7 timer output wrong");
    b0_feeds_a: assert property ($stable(pad_in[PIN_B0]) [*8] |->
        timer_one_ext_clock == pad_in[PIN_B0] && ext_interrupt_a == pad_in[PIN_B0]
        && timer_two_clock_mask == pad_in[PIN_B0]) else $error("b0 input not fed");
    b7_chan_a: assert property ($stable(pad_in[PIN_B7]) [*8] |->
        timer_one_channel2 == pad_in[PIN_B7]) else $error("b7 channel input wrong");
    swd_entry_c: cover property (swd_select ##2 swd_own);
    trace_clk_c: cover property (clk_own ##2 pad_oe[PIN_B0]);
    ch2_out_c: cover property (ch2_own ##2 pad_oe[PIN_B7]);
endmodule // dtpm_sva
bind dtpm_pin_mux dtpm_sva i_dtpm_sva (.*);

// ==== tb/dtpm_board.sv ====
module dtpm_board (
    // Clock
    input  wire logic                      clk,
    // Device pad controls
    input  wire logic [dtpm_pkg::NPIN-1:0] pad_out,
    input  wire logic [dtpm_pkg::NPIN-1:0] pad_oe,
    input  wire logic [dtpm_pkg::NPIN-1:0] pad_pull_up,
    // Debugger and board drive
    input  wire logic [dtpm_pkg::NPIN-1:0] ext_en,
    input  wire logic [dtpm_pkg::NPIN-1:0] ext_val,
    // Resolved pin levels
    output logic      [dtpm_pkg::NPIN-1:0] pad_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    import dtpm_pkg::*;
    logic [NPIN-1:0] float_q = '0;  // Pattern of a floating pin
    // Floating unpulled pins never hold a stale level
    always_ff @(posedge clk) float_q <= ~float_q;
    // Level: X when both drive, else device, else board, else pull-up, else floating
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pad_oe[i] && ext_en[i]) pad_lvl[i] = 1'bx;  // Contention
            else if (pad_oe[i]) pad_lvl[i] = pad_out[i];
            else if (ext_en[i]) pad_lvl[i] = ext_val[i];
            else if (pad_pull_up[i]) pad_lvl[i] = 1'b1;
            else pad_lvl[i] = float_q[i];
        end
    end
endmodule // dtpm_board

// ==== tb/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dtpm_pkg::*;
    logic              clk = 1'b0, reset_n = 1'b0;
    logic              reg_wr = 1'b0, reg_rd = 1'b0, swd_select = 1'b0, jtag_select = 1'b0;
    logic              swdio_out = 1'b0, swdio_oe = 1'b0;
    logic              timer_one_output_enable = 1'b0, timer_one_ch2_out = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    dtpm_trace_t       trace = '0;
    logic [NPIN-1:0]   ext_en = '0, ext_val = '0;  // Board drive
    logic [NPIN-1:0]   pad_in, pad_out, pad_oe, pad_pull_up, pad_analog;
    logic              test_data_in, test_mode_select, test_reset_in_n, swdio_in;
    logic              timer_one_channel2, timer_one_ext_clock, timer_two_clock_mask;
    logic              ext_interrupt_a, ext_interrupt_c, ext_interrupt_d;
    logic [1:0]        widths [3] = '{TRACE_W1, TRACE_W2, TRACE_W4};
    int                n_mismatch = 0, num_checks = 0;
    dtpm_pin_mux i_dtpm_pin_mux (.*);
    dtpm_board i_dtpm_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad_in));
    always #10 clk = ~clk;
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Wait edges, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic t_reset();
        cyc(2);
        chk("pull_up", 6'h0D, pad_pull_up);
        chk("oe", 6'h00, pad_oe);
        chk("analog", 6'h00, pad_analog);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_IRQ_C_SEL, 32'h5);
        rd(OFS_IRQ_D_SEL, 32'h0);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_jtag();
        @(posedge clk) {ext_en, ext_val} <= {6'h0D, 6'h00};
        cyc(8);
        chk("jtag ins", 3'h0, {test_data_in, test_mode_select, test_reset_in_n});
        @(posedge clk) ext_en <= 6'h00;
        cyc(8);
        chk("jtag pulled", 3'h7, {test_data_in, test_mode_select, test_reset_in_n});
    endtask
    task automatic t_gpio();
        wr(OFS_DEBUG_CONFIG, 32'h20);
        wr(OFS_PORT_C_LOW, 32'h1441);
        wr(OFS_PORT_C_HIGH, 32'h4441);
        cyc(8);
        chk("released oe", 6'h0D, pad_oe & 6'h0D);
        chk("not routed", 3'h7, {test_data_in, test_mode_select, test_reset_in_n});
        wr(OFS_GPIO_OUT, 32'h0D);
        cyc(2);
        chk("released out", 6'h0D, pad_out & 6'h0D);
        wr(OFS_DEBUG_CONFIG, 32'h0);
        wr(OFS_PORT_C_LOW, 32'h4444);
        wr(OFS_PORT_C_HIGH, 32'h4444);
    endtask
    task automatic t_swd();
        @(posedge clk) {swd_select, jtag_select} <= 2'b11;
        @(posedge clk) {swd_select, jtag_select} <= 2'b00;
        rd(OFS_STATUS, 32'h1);
        @(posedge clk) {swdio_oe, swdio_out} <= 2'b11;
        cyc(2);
        chk("swd drive", 3'h7, {pad_oe[PIN_C4], pad_out[PIN_C4], pad_pull_up[PIN_C4]});
        @(posedge clk) swdio_oe <= 1'b0;
        @(posedge clk) {ext_en, ext_val} <= {6'h08, 6'h00};
        cyc(8);
        chk("swdio_in", 1'b0, swdio_in);
        chk("unrouted", 2'h3, {test_mode_select, test_reset_in_n});
        @(posedge clk) ext_en <= 6'h00;
        wr(OFS_PORT_C_LOW, 32'h1441);
        wr(OFS_GPIO_OUT, 32'h05);
        cyc(2);
        chk("swd gpio", 4'hF, {pad_oe[PIN_C3], pad_out[PIN_C3], pad_oe[PIN_C0], pad_out[PIN_C0]});
        wr(OFS_PORT_C_LOW, 32'h4444);
        @(posedge clk) jtag_select <= 1'b1;
        @(posedge clk) jtag_select <= 1'b0;
        rd(OFS_STATUS, 32'h0);
    endtask
    task automatic t_analog();
        wr(OFS_PORT_B_LOW, 32'h4440);
        wr(OFS_PORT_C_LOW, 32'h4404);
        wr(OFS_PORT_B_HIGH, 32'h0444);
        cyc(2);
        chk("analog", 6'h32, pad_analog);
        wr(OFS_PORT_B_LOW, 32'h4448);
        wr(OFS_PORT_C_LOW, 32'h4454);
        wr(OFS_PORT_B_HIGH, 32'hD444);
        cyc(2);
        chk("digital", 32'h762, {pad_analog, pad_pull_up, pad_oe});
        wr(OFS_PORT_C_LOW, 32'h4444);
        wr(OFS_PORT_B_HIGH, 32'h4444);
    endtask
    task automatic t_timers();
        for (int v = 0; v < 2; v++) begin
            @(posedge clk) {ext_en, ext_val} <= {6'h31, v[0] ? 6'h31 : 6'h00};
            cyc(8);
            chk("b0 feeds", {3{v[0]}}, {ext_interrupt_a, timer_one_ext_clock, timer_two_clock_mask});
            chk("b7 c0 feeds", {3{v[0]}}, {timer_one_channel2, ext_interrupt_c, ext_interrupt_d});
        end
        wr(OFS_IRQ_C_SEL, 32'h1);
        @(posedge clk) {ext_en, ext_val} <= {6'h33, 6'h02};
        cyc(8);
        chk("remap", 2'h2, {ext_interrupt_c, timer_one_channel2});
        rd(OFS_GPIO_IN, 32'h0E);
        wr(OFS_IRQ_C_SEL, 32'h5);
        @(posedge clk) {ext_en, timer_one_output_enable, timer_one_ch2_out} <= {6'h00, 2'b11};
        wr(OFS_PORT_B_HIGH, 32'h9444);
        cyc(2);
        chk("ch2 out", 2'h3, {pad_oe[PIN_B7], pad_out[PIN_B7]});
        @(posedge clk) timer_one_output_enable <= 1'b0;
        cyc(2);
        chk("ch2 off", 1'b0, pad_out[PIN_B7]);
        wr(OFS_PORT_B_HIGH, 32'h4444);
    endtask
    task automatic t_trace();
        wr(OFS_PORT_B_LOW, 32'h4449);
        wr(OFS_PORT_C_LOW, 32'h4499);
        foreach (widths[i]) begin
            @(posedge clk) trace <= {2'b10, widths[i], 4'b1110};
            cyc(2);
            chk("b0 clk", 2'h3, {pad_oe[PIN_B0], pad_out[PIN_B0]});
            chk("c1 bit0", 2'h3, {pad_oe[PIN_C1], pad_out[PIN_C1]});
            chk("c0 bit1", widths[i] != TRACE_W1, pad_oe[PIN_C0]);
            rd(OFS_STATUS, {30'h0, widths[i] != TRACE_W1, 1'b0});
        end
        @(posedge clk) trace <= {2'b10, TRACE_W4, 4'b0010};
        cyc(2);
        chk("trace out", 6'h01, pad_out & 6'h13);
        @(posedge clk) trace <= {2'b11, TRACE_W1, 4'b0001};
        cyc(2);
        chk("async", 1'b1, pad_out[PIN_C1]);
        @(posedge clk) trace <= '0;
        cyc(2);
        chk("unclaimed", 1'b0, pad_out[PIN_B0]);
    endtask
    task automatic t_rearm();
        @(posedge clk) swd_select <= 1'b1;
        @(posedge clk) {swd_select, reset_n} <= 2'b00;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        #100us;
        n_mismatch++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_jtag();
        t_gpio();
        t_swd();
        t_analog();
        t_timers();
        t_trace();
        t_rearm();
        close_out();
    end
endmodule // tb_top
